// ### hw/led_ind_pkg.sv
// Purpose: Shared constants for the indicator lamp controller.
// Assumes: 125 MHz core clock, 32-bit AXI4-Lite access.
// Notes: Each lamp owns one byte of the configuration word.
package led_ind_pkg;

    // ************************************************************
    // Clock and timing
    // ************************************************************
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned NS_PER_MS = 1000000;
    localparam int unsigned CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
    localparam int unsigned BLINK_HALF_MS = 200;

    // ************************************************************
    // Structure
    // ************************************************************
    localparam int unsigned NUM_LAMPS = 3;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned FIELD_STRIDE = 8;
    localparam int unsigned MODE_LSB = 0;
    localparam int unsigned FLIP_BIT = 6;
    localparam int unsigned BLINK_BIT = 7;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [31:0] CONFIG_RESET = 32'h0007_8B02;
    localparam logic [31:0] CONFIG_MASK = 32'h00CF_CFCF;
    localparam int unsigned STAT_PHASE_BIT = 3;
    localparam int unsigned STAT_LOADED_BIT = 4;
    localparam int unsigned STAT_LINK_BIT = 8;
    localparam int unsigned STAT_ACT_BIT = 9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // Source selector codes
    // ************************************************************
    localparam logic [3:0] SRC_LINK_10_1000 = 4'h0;
    localparam logic [3:0] SRC_LINK_100_1000 = 4'h1;
    localparam logic [3:0] SRC_LINK_ANY = 4'h2;
    localparam logic [3:0] SRC_FILTERED_ACT = 4'h3;
    localparam logic [3:0] SRC_LINK_ACT = 4'h4;
    localparam logic [3:0] SRC_LINK_10 = 4'h5;
    localparam logic [3:0] SRC_LINK_100 = 4'h6;
    localparam logic [3:0] SRC_LINK_1000 = 4'h7;
    localparam logic [3:0] SRC_PIN_MIRROR = 4'h8;
    localparam logic [3:0] SRC_FULL_DUPLEX = 4'h9;
    localparam logic [3:0] SRC_COLLISION = 4'hA;
    localparam logic [3:0] SRC_ACTIVITY = 4'hB;
    localparam logic [3:0] SRC_LINK_10_100 = 4'hC;
    localparam logic [3:0] SRC_TRANSMIT_HELD = 4'hD;
    localparam logic [3:0] SRC_LAMP_FORCED_LIT = 4'hE;
    localparam logic [3:0] SRC_LAMP_FORCED_DARK = 4'hF;

    typedef enum logic {LOAD_WAIT, LOAD_DONE} load_state_t;

endpackage

// ### hw/pin_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for pin inputs.
// Assumes: Inputs are asynchronous to aclk.
// Notes: The output moves only when the second and third stages agree.
`timescale 1ns/1ps
module pin_sync #(
    parameter int unsigned WIDTH = 3
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] pin_async,
    output logic [WIDTH-1:0] pin_clean
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] s2_ff;
    logic [WIDTH-1:0] s3_ff;
    logic [WIDTH-1:0] clean_ff;
    logic [WIDTH-1:0] agree;

    // The first stage feeds only the second, so a metastable level never
    // reaches the comparator.
    assign agree = ~(s2_ff ^ s3_ff);
    assign pin_clean = clean_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            meta_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
            clean_ff <= '0;
        end
        else if (ce)
        begin
            meta_ff <= pin_async;
            s2_ff <= meta_ff;
            s3_ff <= s2_ff;
            clean_ff <= (agree & s3_ff) | (~agree & clean_ff);
        end
    end

endmodule

// ### hw/blink_timer.sv
// Purpose: Shared blink phase generator built on a millisecond tick.
// Assumes: One tick of the prescaler per CYC_PER_MS enabled clocks.
// Notes: All lamps share this phase and blink in step.
`timescale 1ns/1ps
module blink_timer #(
    parameter int unsigned CYC_PER_MS = 125000,
    parameter int unsigned HALF_MS = 200
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    output logic phase
);

    localparam int unsigned CW = $clog2(CYC_PER_MS);
    localparam int unsigned MW = $clog2(HALF_MS);
    localparam logic [CW-1:0] CYC_LAST = CW'(CYC_PER_MS - 1);
    localparam logic [MW-1:0] MS_LAST = MW'(HALF_MS - 1);

    logic [CW-1:0] cyc_ff;
    logic [MW-1:0] ms_ff;
    logic phase_ff;
    logic ms_tick;
    logic half_done;

    assign ms_tick = (cyc_ff == CYC_LAST);
    assign half_done = ms_tick && (ms_ff == MS_LAST);
    assign phase = phase_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cyc_ff <= '0;
            ms_ff <= '0;
            phase_ff <= 1'b1;
        end
        else if (ce)
        begin
            cyc_ff <= ms_tick ? '0 : cyc_ff + CW'(1);
            if (ms_tick)
            begin
                ms_ff <= half_done ? '0 : ms_ff + MW'(1);
            end
            if (half_done)
            begin
                phase_ff <= ~phase_ff;
            end
        end
    end

endmodule

// ### hw/led_indicator_control.sv
// Purpose: Three configurable indicator lamp drivers with AXI4-Lite access.
// Assumes: Link and traffic status inputs come from logic on aclk;
//          software pins are synchronised here.
// Notes: Lamp pins are active low, sinking the lamp cathode.
//
// Operation
// - Three lamp outputs, each with own source, polarity and blink settings.
// - Four-bit selector per lamp; 1110b forces lit, 1111b forces dark.
// - Polarity flip inverts the source before blink logic and pin.
// - Blink enabled: 200 ms lit, 200 ms dark while source asserted.
// - Link-and-traffic with blink: dark, steady without traffic, else blink.
// - 0000b 10/1000 link, 0001b 100/1000 link, 1100b 10/100 link.
// - 0101b, 0110b, 0111b assert only for exact 10, 100, 1000 link.
// - 0010b asserts for a link at any speed.
// - 0011b asserts with link and filtered frames moving.
// - 0100b without blink asserts with link and no traffic.
// - 1000b mirrors software pin of the same index.
// - 1001b asserts with link in full duplex, deasserts in half duplex.
// - 1010b asserts while a collision is observed.
// - 1011b asserts with link and any frames moving.
// - 1101b asserts while the transmitter is held by flow control.
// - After reset the configuration loads defaults from the config store unless a software config write comes first.
//
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
module led_indicator_control
    import led_ind_pkg::*;
#(
    parameter int unsigned CYC_PER_MS = led_ind_pkg::CYCLES_PER_MS,
    parameter int unsigned LAMPS = led_ind_pkg::NUM_LAMPS
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [led_ind_pkg::ADDR_W-1:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [led_ind_pkg::ADDR_W-1:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire logic link_up,
    input wire logic speed_10,
    input wire logic speed_100,
    input wire logic speed_1000,
    input wire logic full_duplex,
    input wire logic collision_seen,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic filtered_active,
    input wire logic transmit_held,
    input wire logic software_pin_zero,
    input wire logic software_pin_one,
    input wire logic software_pin_two,
    input wire logic [31:0] integrated_config_store_word,
    input wire logic integrated_config_store_valid,
    output logic [2:0] lamp_n
);

    import led_ind_pkg::*;

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    generate
        if (LAMPS != 3)
        begin : g_bad_lamps
            $error("Lamp count must be three.");
        end
        if (CYC_PER_MS < 2)
        begin : g_bad_ms
            $error("Prescale must be at least two.");
        end
    endgenerate

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic logic [31:0] apply_strobe(input logic [31:0] old_val,
                                                 input logic [31:0] new_val,
                                                 input logic [3:0] strb);
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++)
        begin
            if (strb[b])
            begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic pick_source(input logic [3:0] mode,
                                         input logic mirror_pin,
                                         input logic blink_on,
                                         input logic [9:0] st);
        // st: {held, filt, act, coll, fdx, s1000, s100, s10, link, spare}
        logic lnk;
        logic act;
        logic res;
        lnk = st[1];
        act = st[7];
        res = 1'b0;
        case (mode)
            SRC_LINK_10_1000: res = lnk & (st[2] | st[4]);
            SRC_LINK_100_1000: res = lnk & (st[3] | st[4]);
            SRC_LINK_10_100: res = lnk & (st[2] | st[3]);
            SRC_LINK_ANY: res = lnk;
            SRC_FILTERED_ACT: res = lnk & st[8];
            SRC_LINK_ACT: res = blink_on ? lnk : (lnk & ~act);
            SRC_LINK_10: res = lnk & st[2];
            SRC_LINK_100: res = lnk & st[3];
            SRC_LINK_1000: res = lnk & st[4];
            SRC_PIN_MIRROR: res = mirror_pin;
            SRC_FULL_DUPLEX: res = lnk & st[5];
            SRC_COLLISION: res = st[6];
            SRC_ACTIVITY: res = lnk & act;
            SRC_TRANSMIT_HELD: res = st[9];
            SRC_LAMP_FORCED_LIT: res = 1'b1;
            SRC_LAMP_FORCED_DARK: res = 1'b0;
            default: res = 1'b0;
        endcase
        return res;
    endfunction

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [31:0] indicator_config_reg_ff;
    logic [31:0] nxt_indicator_config_reg;
    load_state_t load_state_ff;
    load_state_t nxt_load_state;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    logic [2:0] lamp_n_ff;
    logic [2:0] pins_clean;
    logic blink_phase;
    logic [2:0] lamp_lit;
    logic [9:0] status_vec;
    logic any_activity;
    logic wr_fire;
    logic rd_fire;
    logic wr_hit_config;
    logic wr_hit_status;
    logic rd_hit_config;
    logic rd_hit_status;
    logic [31:0] status_word;
    logic [31:0] rd_word;
    logic [31:0] written_config;

    // ************************************************************
    // Submodules
    // ************************************************************
    pin_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .pin_async({software_pin_two, software_pin_one, software_pin_zero}),
        .pin_clean(pins_clean)
    );

    blink_timer #(
        .CYC_PER_MS(CYC_PER_MS),
        .HALF_MS(BLINK_HALF_MS)
    ) u_blink_timer (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .phase(blink_phase)
    );

    // ************************************************************
    // Lamp datapath
    // ************************************************************
    assign any_activity = tx_active | rx_active;
    assign status_vec = {transmit_held, filtered_active, any_activity, collision_seen,
                         full_duplex, speed_1000, speed_100, speed_10, link_up, 1'b0};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_lamp
            wire logic [3:0] mode;
            wire logic flip;
            wire logic blink_on;
            wire logic raw_src;
            wire logic src;
            wire logic linkact_blink;
            assign mode = indicator_config_reg_ff[gi*FIELD_STRIDE + MODE_LSB +: 4];
            assign flip = indicator_config_reg_ff[gi*FIELD_STRIDE + FLIP_BIT];
            assign blink_on = indicator_config_reg_ff[gi*FIELD_STRIDE + BLINK_BIT];
            assign raw_src = pick_source(mode, pins_clean[gi], blink_on, status_vec);
            // The flip happens ahead of the blink gate, so a flipped dark source
            // blinks; software is expected to avoid that pairing.
            assign src = raw_src ^ flip;
            assign linkact_blink = (mode == SRC_LINK_ACT) && !any_activity;
            // A dark source stays dark whatever the phase.
            assign lamp_lit[gi] = blink_on ? (src & (blink_phase | linkact_blink)) : src;
        end
    endgenerate

    // ************************************************************
    // Bus decode
    // ************************************************************
    // Address and data are taken together; a master offering one waits.
    assign wr_fire = ce && s_axil_awvalid && s_axil_wvalid && !bvalid_ff;
    assign rd_fire = ce && s_axil_arvalid && !rvalid_ff;
    assign s_axil_awready = wr_fire;
    assign s_axil_wready = wr_fire;
    assign s_axil_arready = rd_fire;
    assign wr_hit_config = (s_axil_awaddr[ADDR_W-1:2] == ADDR_CONFIG[ADDR_W-1:2]);
    assign wr_hit_status = (s_axil_awaddr[ADDR_W-1:2] == ADDR_STATUS[ADDR_W-1:2]);
    assign rd_hit_config = (s_axil_araddr[ADDR_W-1:2] == ADDR_CONFIG[ADDR_W-1:2]);
    assign rd_hit_status = (s_axil_araddr[ADDR_W-1:2] == ADDR_STATUS[ADDR_W-1:2]);
    assign written_config = apply_strobe(indicator_config_reg_ff, s_axil_wdata,
                                         s_axil_wstrb) & CONFIG_MASK;

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[2:0] = lamp_lit;
        status_word[STAT_PHASE_BIT] = blink_phase;
        status_word[STAT_LOADED_BIT] = (load_state_ff == LOAD_DONE);
        status_word[STAT_LINK_BIT] = link_up;
        status_word[STAT_ACT_BIT] = any_activity;
    end

    assign rd_word = rd_hit_config ? indicator_config_reg_ff :
                     (rd_hit_status ? status_word : 32'h0000_0000);

    // ************************************************************
    // Configuration register and default load
    // ************************************************************
    // A software write before the store answers wins and ends the load,
    // so a late store word never overwrites a deliberate setting.
    always_comb
    begin
        nxt_indicator_config_reg = indicator_config_reg_ff;
        nxt_load_state = load_state_ff;
        case (load_state_ff)
            LOAD_WAIT:
            begin
                if (wr_fire && wr_hit_config)
                begin
                    nxt_indicator_config_reg = written_config;
                    nxt_load_state = LOAD_DONE;
                end
                else if (integrated_config_store_valid)
                begin
                    nxt_indicator_config_reg = integrated_config_store_word & CONFIG_MASK;
                    nxt_load_state = LOAD_DONE;
                end
            end
            LOAD_DONE:
            begin
                if (wr_fire && wr_hit_config)
                begin
                    nxt_indicator_config_reg = written_config;
                end
            end
            default:
            begin
                nxt_load_state = LOAD_DONE;
            end
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            indicator_config_reg_ff <= CONFIG_RESET;
            load_state_ff <= LOAD_WAIT;
        end
        else if (ce)
        begin
            indicator_config_reg_ff <= nxt_indicator_config_reg;
            load_state_ff <= nxt_load_state;
        end
    end

    // ************************************************************
    // Bus responses
    // ************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (wr_fire)
            begin
                bvalid_ff <= 1'b1;
                bresp_ff <= (wr_hit_config || wr_hit_status) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axil_bready)
            begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end
        else if (ce)
        begin
            if (rd_fire)
            begin
                rvalid_ff <= 1'b1;
                rdata_ff <= rd_word;
                rresp_ff <= (rd_hit_config || rd_hit_status) ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_axil_rready)
            begin
                rvalid_ff <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Lamp pins
    // ************************************************************
    // Pins are registered so lamp edges are glitch free; low lights a lamp.
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            lamp_n_ff <= 3'h7;
        end
        else if (ce)
        begin
            lamp_n_ff <= ~lamp_lit;
        end
    end

    assign lamp_n = lamp_n_ff;
    assign s_axil_bvalid = bvalid_ff;
    assign s_axil_bresp = bresp_ff;
    assign s_axil_rvalid = rvalid_ff;
    assign s_axil_rdata = rdata_ff;
    assign s_axil_rresp = rresp_ff;

endmodule

// ### sim/led_ind_props.sv
// Purpose: Concurrent checks on the lamp controller ports.
// Assumes: Lamp 0 settings are tracked from bus writes.
// Notes: Lamp checks start at the first write to the lamp 0 configuration byte.
`timescale 1ns/1ps
module led_ind_props
    import led_ind_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    input wire logic [led_ind_pkg::ADDR_W-1:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    input wire logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    input wire logic s_axil_bvalid,
    input wire logic s_axil_arvalid,
    input wire logic s_axil_rvalid,
    input wire logic link_up,
    input wire logic speed_10,
    input wire logic speed_100,
    input wire logic speed_1000,
    input wire logic full_duplex,
    input wire logic collision_seen,
    input wire logic tx_active,
    input wire logic rx_active,
    input wire logic filtered_active,
    input wire logic transmit_held,
    input wire logic [2:0] lamp_n
);
    logic [7:0] cfg_ff;
    logic known_ff;
    wire logic [9:0] v = {transmit_held, filtered_active, rx_active, tx_active, collision_seen,
        full_duplex, speed_1000, speed_100, speed_10, link_up};
    wire logic [3:0] md = cfg_ff[3:0];
    wire logic wr0 = s_axil_awready && s_axil_awaddr[7:2] == 6'h00 && s_axil_wstrb[0];

    function automatic logic src(input logic [3:0] m, input logic b, input logic [9:0] s);
        case (m)
            4'h0: return s[0] & (s[1] | s[3]);
            4'h1: return s[0] & (s[2] | s[3]);
            4'h2: return s[0];
            4'h3: return s[0] & s[8];
            4'h4: return s[0] & (b | !(s[6] | s[7]));
            4'h5: return s[0] & s[1];
            4'h6: return s[0] & s[2];
            4'h7: return s[0] & s[3];
            4'h9: return s[0] & s[4];
            4'hA: return s[5];
            4'hB: return s[0] & (s[6] | s[7]);
            4'hC: return s[0] & (s[1] | s[2]);
            4'hD: return s[9];
            4'hE: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Expected active-low pin level one clock later.
    wire logic hold_n = !(src(md, cfg_ff[7], v) ^ cfg_ff[6]);

    always_ff @(posedge aclk)
    begin
        known_ff <= aresetn && (known_ff || wr0);
        if (wr0)
            cfg_ff <= s_axil_wdata[7:0];
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wr_taken;
        ce && s_axil_awvalid && s_axil_wvalid && !s_axil_bvalid;
    endsequence

    property follows(ok);
        known_ff && ce && !cfg_ff[7] && ok |=> lamp_n[0] == $past(hold_n);
    endproperty

    chk_write_answer: assert property (wr_taken |=> s_axil_bvalid)
        else $error("write response missing");
    chk_read_answer: assert property (ce && s_axil_arvalid && !s_axil_rvalid |=> s_axil_rvalid)
        else $error("read response missing");
    chk_forced_levels: assert property (follows(md inside {4'hE, 4'hF}))
        else $error("forced lamp level wrong");
    chk_speed_link: assert property (follows(md inside {[4'h0:4'h2], [4'h5:4'h7], 4'hC}))
        else $error("link speed lamp wrong");
    chk_traffic_modes: assert property (follows(md inside {4'h3, 4'h4, 4'hB}))
        else $error("traffic lamp wrong");
    chk_line_state: assert property (follows(md inside {4'h9, 4'hA, 4'hD}))
        else $error("duplex, collision or held lamp wrong");
    chk_flip_inverts: assert property (follows(cfg_ff[6] && md != 4'h8))
        else $error("inverted lamp wrong");
    chk_blink_dark: assert property (known_ff && ce && cfg_ff[7] && md != 4'h8 && hold_n |=> lamp_n[0])
        else $error("blinking lamp lit with dark source");
    chk_steady_link: assert property (known_ff && ce && cfg_ff == 8'h84 && v[0] && !v[6] && !v[7]
        |=> !lamp_n[0])
        else $error("link lamp not steady");
endmodule

bind led_indicator_control led_ind_props props (.*);

// ### sim/lamp_model.sv
// Purpose: Model of the three external lamps on the lamp pins.
// Assumes: Each pin sinks its lamp cathode, so a low pin lights the lamp.
// Notes: Reports lamp state as active-high lit flags.
`timescale 1ns/1ps
module lamp_model (
    input wire logic [2:0] lamp_n,
    output logic [2:0] lit
);
    // The lamp conducts only while the pin pulls its cathode low.
    assign lit = ~lamp_n;
endmodule

// ### sim/test_led_indicator_control.sv
// Purpose: Self-checking bench for the indicator lamp controller.
// Assumes: Enable held high; ms prescale cut to ten cycles.
// Notes: Lamp state is observed through the lamp model.
`timescale 1ns/1ps
module test_led_indicator_control;
    import led_ind_pkg::*;
    localparam int unsigned CPM = 10;
    localparam int HALF = BLINK_HALF_MS * CPM;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic ce = 1'b1;
    logic [7:0] s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
    logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata;
    logic [3:0] s_axil_wstrb = 4'h0;
    logic s_axil_awvalid = 1'b0, s_axil_wvalid = 1'b0, s_axil_bready = 1'b0;
    logic s_axil_arvalid = 1'b0, s_axil_rready = 1'b0;
    logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
    logic [1:0] s_axil_bresp, s_axil_rresp;
    logic [9:0] st = 10'h000;
    logic [2:0] pins = 3'h4;
    logic [2:0] lamp_n, lit;
    logic [15:0] t;
    logic p;
    int num_errors = 0, n_checks = 0, k, n;
    // Entry: bit 14 lit, bits 13:10 source code, bits 9:0 status.
    logic [15:0] tbl [25] = '{16'h4009, 16'h0005, 16'h4405, 16'h0403, 16'h4801, 16'h0808,
        16'h0C41, 16'h4D01, 16'h5001, 16'h1081, 16'h5403, 16'h1405, 16'h5805, 16'h5C09,
        16'h1C05, 16'h6411, 16'h2401, 16'h6820, 16'h6C81, 16'h2C80, 16'h7003, 16'h3009,
        16'h7600, 16'h7800, 16'h3FFF};

    led_indicator_control #(.CYC_PER_MS(CPM)) dut (
        .*,
        .link_up(st[0]), .speed_10(st[1]), .speed_100(st[2]), .speed_1000(st[3]),
        .full_duplex(st[4]), .collision_seen(st[5]), .tx_active(st[6]), .rx_active(st[7]),
        .filtered_active(st[8]), .transmit_held(st[9]),
        .software_pin_zero(pins[0]), .software_pin_one(pins[1]), .software_pin_two(pins[2]),
        .integrated_config_store_word(32'hFF38_8B0E),
        .integrated_config_store_valid(1'b1)
    );
    lamp_model lamps (.lamp_n(lamp_n), .lit(lit));

    always #4 aclk = ~aclk;

    task automatic finish_test();
        if (num_errors == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic hang(input int i);
        if (i >= 200)
        begin
            num_errors++;
            finish_test();
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge aclk);
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                       input logic [1:0] er);
        int i = 0;
        @(posedge aclk);
        s_axil_awaddr <= a;
        s_axil_wdata <= d;
        s_axil_wstrb <= s;
        s_axil_awvalid <= 1'b1;
        s_axil_wvalid <= 1'b1;
        s_axil_bready <= 1'b1;
        do @(posedge aclk); while (s_axil_awready !== 1'b1 && ++i < 200);
        s_axil_awvalid <= 1'b0;
        s_axil_wvalid <= 1'b0;
        do @(posedge aclk); while (s_axil_bvalid !== 1'b1 && ++i < 200);
        s_axil_bready <= 1'b0;
        hang(i);
        cmp({30'h0, s_axil_bresp}, {30'h0, er});
    endtask

    task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int i = 0;
        @(posedge aclk);
        s_axil_araddr <= a;
        s_axil_arvalid <= 1'b1;
        s_axil_rready <= 1'b1;
        do @(posedge aclk); while (s_axil_arready !== 1'b1 && ++i < 200);
        s_axil_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axil_rvalid !== 1'b1 && ++i < 200);
        s_axil_rready <= 1'b0;
        hang(i);
        cmp(s_axil_rdata, ed);
        cmp({30'h0, s_axil_rresp}, {30'h0, er});
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        tick(12);
        axr(ADDR_CONFIG, 32'h0008_8B0E, RESP_OKAY);
        cmp({29'h0, lit}, 32'h5);
        axr(ADDR_STATUS, 32'h0000_001D, RESP_OKAY);
        axr(8'h08, 32'h0, RESP_SLVERR);
        axw(8'h0C, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
        axw(ADDR_CONFIG, 32'h0000_0808, 4'h3, RESP_OKAY);
        axr(ADDR_CONFIG, 32'h0008_0808, RESP_OKAY);
        for (k = 3; k < 7; k += 3)
        begin
            pins <= k[2:0];
            tick(10);
            cmp({29'h0, lit}, k);
        end
        // Lamps 1 and 2 go on mirroring high pins.
        for (k = 0; k < 50; k++)
        begin
            t = tbl[k % 25];
            st <= t[9:0];
            axw(ADDR_CONFIG, {24'h0, 1'b0, k >= 25, 2'h0, t[13:10]}, 4'h1, RESP_OKAY);
            tick(2);
            cmp({29'h0, lit}, {29'h0, 2'h3, t[14] ^ (k >= 25)});
        end
        st <= 10'h081;
        axw(ADDR_CONFIG, 32'h0000_0084, 4'h1, RESP_OKAY);
        tick(3);
        // The first pass only finds a true phase edge.
        for (k = 0; k < 3; k++)
        begin
            p = lit[0];
            n = 0;
            do @(posedge aclk); while (lit[0] === p && ++n < 5000);
            if (k > 0)
                cmp(n + 1, HALF);
        end
        for (k = 1; k >= 0; k--)
        begin
            st <= k[9:0];
            tick(3);
            n = 0;
            repeat (4500)
            begin
                @(posedge aclk);
                n += lit[0];
            end
            cmp(n, 4500 * k);
        end
        finish_test();
    end
endmodule
